//--- scu_pkg.sv
// Shared constants of the serial unit: register map, field positions,
// reset values and bit timing. Assumes a 100 MHz aclk.
package scu_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned SAMPLE_PT = 8;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned TK_W = $clog2(OVERSAMPLE);
  localparam int unsigned BIT_W = $clog2(DATA_BITS);
  localparam logic [TK_W-1:0] TK_LAST = TK_W'(OVERSAMPLE - 1);
  localparam logic [TK_W-1:0] TK_MID = TK_W'(SAMPLE_PT);
  localparam logic [TK_W-1:0] TK_PRE = TK_W'(SAMPLE_PT - 1);
  localparam logic [BIT_W-1:0] BIT_LAST = BIT_W'(DATA_BITS - 1);
  localparam int unsigned AXI_DW = 32;
  localparam int unsigned NREG = 7;
  localparam int REG_CTRL = 0;
  localparam int REG_BAUD = 1;
  localparam int REG_STAT = 2;
  localparam int REG_TXD = 3;
  localparam int REG_RXD = 4;
  localparam int REG_ISTAT = 5;
  localparam int REG_IMASK = 6;
  localparam logic [NREG-1:0][7:0] REG_OFF = {
    8'h18, 8'h14, 8'h10, 8'h0C, 8'h08, 8'h04, 8'h00};
  localparam int unsigned CTRL_W = 8;
  localparam int CT_TX_EN = 0;
  localparam int CT_RX_EN = 1;
  localparam int CT_SYNC = 2;
  localparam int CT_RIE = 3;
  localparam int CT_LATCH = 4;
  localparam int CT_DIR = 5;
  localparam int CT_PAR_EN = 6;
  localparam int CT_PAR_ODD = 7;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  localparam int unsigned BAUD_W = 16;
  localparam logic [BAUD_W-1:0] BAUD_RST = 16'h0035;
  localparam int unsigned STAT_W = 7;
  localparam int ST_TBE = 0;
  localparam int ST_RECEIVE_FULL_FLAG = 1;
  localparam int ST_OVERRUN_FLAG = 2;
  localparam int ST_FER = 3;
  localparam int ST_PER = 4;
  localparam int ST_PIN = 5;
  localparam int ST_ACT = 6;
  localparam int unsigned NIRQ = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- scu_link_if.sv
// Carrier between the serial core and its transmitter and receiver.
// Assumes all three ends run on the same aclk.
`timescale 1ns/100ps
interface scu_link_if;
  logic base_tick;
  logic sync_mode;
  logic par_en;
  logic par_odd;
  logic tx_en;
  logic tx_go;
  logic [7:0] tx_data;
  logic tx_take;
  logic tx_active;
  logic tx_sout;
  logic sclk;
  logic sclk_rise;
  logic rx_en;
  logic rxd;
  logic rx_done;
  logic rx_ferr;
  logic rx_perr;
  logic [7:0] rx_data;
  modport ctl (output base_tick, sync_mode, par_en, par_odd, tx_en, tx_go, tx_data,
    rx_en, rxd, input tx_take, tx_active, tx_sout, sclk, sclk_rise, rx_done,
    rx_ferr, rx_perr, rx_data);
  modport tx (input base_tick, sync_mode, par_en, par_odd, tx_en, tx_go, tx_data,
    output tx_take, tx_active, tx_sout, sclk, sclk_rise);
  modport rx (input base_tick, sync_mode, par_en, par_odd, rx_en, rxd, sclk_rise,
    output rx_done, rx_ferr, rx_perr, rx_data);
endinterface

//--- scu_tx.sv
// Transmit shifter: async frames or clocked 8-bit frames.
// Assumes base_tick at 16x bit rate and a synchronous tx_go request.
`timescale 1ns/100ps
module scu_tx (
  input wire logic aclk,
  input wire logic aresetn,
  scu_link_if.tx lk
);
  import scu_pkg::*;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} scu_tx_st_t;
  scu_tx_st_t st_ff;
  logic [TK_W-1:0] tk_ff;
  logic [BIT_W-1:0] bit_ff;
  logic [DATA_BITS-1:0] sh_ff;
  logic par_ff;
  logic out_ff;
  logic take_ff;
  logic sclk_ff;
  logic rise_ff;
  logic busy;
  logic bit_end;
  assign busy = (st_ff != TX_IDLE);
  assign bit_end = lk.base_tick && (tk_ff == TK_LAST);
  assign lk.tx_take = take_ff;
  assign lk.tx_active = busy;
  assign lk.tx_sout = out_ff;
  assign lk.sclk = sclk_ff;
  assign lk.sclk_rise = rise_ff;

  always_ff @(posedge aclk) begin
    // Disable aborts any frame at once
    if (!aresetn || !lk.tx_en) begin // [RULE11]
      st_ff <= TX_IDLE;
      tk_ff <= '0;
      bit_ff <= '0;
      sh_ff <= '0;
      par_ff <= 1'b0;
      out_ff <= 1'b1;
      take_ff <= 1'b0;
      sclk_ff <= 1'b1;
      rise_ff <= 1'b0;
    end else begin
      take_ff <= 1'b0;
      sclk_ff <= !(lk.sync_mode && st_ff == TX_DATA && tk_ff < TK_MID);
      rise_ff <= lk.sync_mode && st_ff == TX_DATA && lk.base_tick && tk_ff == TK_PRE;
      if (!busy && lk.tx_go) begin
        sh_ff <= lk.tx_data;
        par_ff <= (^lk.tx_data) ^ lk.par_odd;
        take_ff <= 1'b1; // [RULE1]
        tk_ff <= '0;
        bit_ff <= '0;
        st_ff <= lk.sync_mode ? TX_DATA : TX_START;
        out_ff <= lk.sync_mode ? lk.tx_data[0] : 1'b0;
      end else if (busy && lk.base_tick) begin
        tk_ff <= bit_end ? '0 : tk_ff + 1'b1;
        if (bit_end) begin
          case (st_ff)
            TX_START: begin
              st_ff <= TX_DATA;
              out_ff <= sh_ff[0];
            end
            TX_DATA: begin
              if (bit_ff == BIT_LAST) begin
                // Clocked mode holds the last bit on the line
                st_ff <= lk.sync_mode ? TX_IDLE : (lk.par_en ? TX_PAR : TX_STOP);
                out_ff <= lk.sync_mode ? out_ff : (lk.par_en ? par_ff : 1'b1);
              end else begin
                sh_ff <= sh_ff >> 1;
                out_ff <= sh_ff[1];
                bit_ff <= bit_ff + 1'b1;
              end
            end
            TX_PAR: begin
              st_ff <= TX_STOP;
              out_ff <= 1'b1;
            end
            TX_STOP: st_ff <= TX_IDLE;
            default: st_ff <= TX_IDLE;
          endcase
        end
      end
    end
  end
endmodule

//--- scu_rx.sv
// Receive shifter: 16x oversampled async frames or clocked 8-bit frames.
// Assumes rxd already synchronised to aclk; clocked mode needs the transmitter.
`timescale 1ns/100ps
module scu_rx (
  input wire logic aclk,
  input wire logic aresetn,
  scu_link_if.rx lk
);
  import scu_pkg::*;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} scu_rx_st_t;
  scu_rx_st_t st_ff;
  logic [TK_W-1:0] tk_ff;
  logic [BIT_W-1:0] bit_ff;
  logic [DATA_BITS-1:0] sh_ff;
  logic done_ff;
  logic ferr_ff;
  logic perr_ff;
  logic smp;
  logic detect;
  // Eighth tick after the detecting tick, not the ninth
  assign smp = lk.sync_mode ? lk.sclk_rise : (lk.base_tick && tk_ff == TK_PRE); // [RULE15]
  assign detect = !lk.sync_mode && lk.base_tick && !lk.rxd; // [RULE14]
  assign lk.rx_done = done_ff;
  assign lk.rx_ferr = ferr_ff;
  assign lk.rx_perr = perr_ff;
  assign lk.rx_data = sh_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn || !lk.rx_en) begin
      st_ff <= RX_IDLE;
      tk_ff <= '0;
      bit_ff <= '0;
      sh_ff <= '0;
      done_ff <= 1'b0;
      ferr_ff <= 1'b0;
      perr_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (st_ff != RX_IDLE && lk.base_tick) begin
        tk_ff <= (tk_ff == TK_LAST) ? '0 : tk_ff + 1'b1;
      end
      case (st_ff)
        RX_IDLE: begin
          tk_ff <= '0;
          bit_ff <= '0;
          perr_ff <= 1'b0;
          // A break keeps restarting frames, so framing errors recur
          if (detect) begin // [RULE6]
            st_ff <= RX_START;
          end else if (lk.sync_mode && smp) begin
            sh_ff <= {lk.rxd, sh_ff[DATA_BITS-1:1]};
            bit_ff <= BIT_W'(1);
            st_ff <= RX_DATA;
          end
        end
        RX_START: begin
          if (smp) begin
            st_ff <= lk.rxd ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (smp) begin
            sh_ff <= {lk.rxd, sh_ff[DATA_BITS-1:1]};
            bit_ff <= bit_ff + 1'b1;
            if (bit_ff == BIT_LAST) begin
              st_ff <= lk.sync_mode ? RX_IDLE : (lk.par_en ? RX_PAR : RX_STOP);
              done_ff <= lk.sync_mode;
              ferr_ff <= 1'b0;
            end
          end
        end
        RX_PAR: begin
          if (smp) begin
            perr_ff <= ((^sh_ff) ^ lk.rxd) != lk.par_odd;
            st_ff <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (smp) begin
            ferr_ff <= !lk.rxd;
            done_ff <= 1'b1;
            st_ff <= RX_IDLE;
          end
        end
        default: st_ff <= RX_IDLE;
      endcase
    end
  end
endmodule

//--- scu_top.sv
// Serial unit core: AXI4-Lite registers, receive flags, pin muxing, interrupts.
// Assumes one AXI4-Lite master on aclk; rxd_pin is asynchronous to aclk.
//
// What this block does
// RULE1: Buffer-empty flag sets when shifter loads
// RULE2: Holding writes always accepted, overwrite pending byte
// RULE3: Software checks empty flag before writing
// RULE4: Overrun keeps full, sets errors, drops byte
// RULE5: Errors without overrun copy byte, full stays
// RULE6: Break keeps receiver running, framing error recurs
// RULE7: Software reads input pin to spot break
// RULE8: Transmit disabled gives pin to port latch
// RULE9: Software presets port latch and direction high
// RULE10: Break sent by latch low, then disable
// RULE11: Disabling transmit resets transmitter at once
// RULE12: Clocked mode: errors block transmit start
// RULE13: Receive disable keeps error flags intact
// RULE14: Async receive oversamples 16x, aligns start
// RULE15: Bits sampled on eighth base tick
// RULE16: External clock waits five cycles after load; here sclk is always driven by the transmitter
// RULE17: Error flags raise error request when enabled
// RULE18: Full flag raises full request when enabled
// RULE19: Flags clear by zero-write after reading one
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module scu_top #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [scu_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [scu_pkg::AXI_DW/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [scu_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxd_pin,
  output logic txd_out,
  output logic txd_oe_n,
  output logic sclk_out,
  output logic sclk_oe_n,
  output logic rx_error_irq,
  output logic rx_full_irq,
  output logic irq
);
  import scu_pkg::*;

  scu_link_if lk ();

  logic [CTRL_W-1:0] ctrl_ff;
  logic [BAUD_W-1:0] baud_ff;
  logic [BAUD_W-1:0] div_ff;
  logic tick_ff;
  logic rxs1_ff;
  logic rxs2_ff;
  logic tbe_ff;
  logic receive_full_flag_ff;
  logic overrun_flag_ff;
  logic fer_ff;
  logic per_ff;
  logic [STAT_W-1:0] seen_ff;
  logic [7:0] hold_ff;
  logic [7:0] rbuf_ff;
  logic [NIRQ-1:0] ist_ff;
  logic [NIRQ-1:0] imask_ff;
  logic aw_got_ff;
  logic w_got_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [AXI_DW-1:0] wdata_ff;
  logic [AXI_DW/8-1:0] wstrb_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [AXI_DW-1:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic txd_ff;
  logic txd_oe_n_ff;
  logic sclk_ff;
  logic sclk_oe_n_ff;
  logic err_irq_ff;
  logic full_irq_ff;
  logic irq_ff;

  function automatic logic [NREG-1:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [NREG-1:0] s;
    s = '0;
    for (int i = 0; i < NREG; i++) begin
      if (a == ADDR_W'(REG_OFF[i])) begin
        s[i] = 1'b1;
      end
    end
    return s;
  endfunction

  function automatic logic [AXI_DW-1:0] be_merge(
    input logic [AXI_DW-1:0] old_w,
    input logic [AXI_DW-1:0] new_w,
    input logic [AXI_DW/8-1:0] strb
  );
    logic [AXI_DW-1:0] m;
    m = old_w;
    for (int b = 0; b < AXI_DW / 8; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return m;
  endfunction

  // Write channel: address and data are taken in either order
  logic aw_hs;
  logic w_hs;
  logic wr_go;
  logic [NREG-1:0] wsel;
  logic [NREG-1:0] wr_en;
  logic nxt_aw_got;
  logic nxt_w_got;
  logic nxt_bvalid;
  assign aw_hs = s_axi_awvalid && awready_ff;
  assign w_hs = s_axi_wvalid && wready_ff;
  assign wr_go = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wsel = reg_sel(awaddr_ff);
  assign wr_en = {NREG{wr_go}} & wsel;
  assign nxt_aw_got = !wr_go && (aw_got_ff || aw_hs);
  assign nxt_w_got = !wr_go && (w_got_ff || w_hs);
  assign nxt_bvalid = wr_go || (bvalid_ff && !s_axi_bready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      awready_ff <= !nxt_aw_got && !nxt_bvalid;
      wready_ff <= !nxt_w_got && !nxt_bvalid;
      bvalid_ff <= nxt_bvalid;
      if (wr_go) begin
        bresp_ff <= (|wsel) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else begin
      if (aw_hs) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  // Read channel: one-cycle answer from a registered mux
  logic ar_hs;
  logic [NREG-1:0] rsel;
  logic [STAT_W-1:0] stat_w;
  logic [AXI_DW-1:0] rd_word;
  logic nxt_rvalid;
  assign ar_hs = s_axi_arvalid && arready_ff;
  assign rsel = reg_sel(s_axi_araddr);
  assign nxt_rvalid = ar_hs || (rvalid_ff && !s_axi_rready);
  // Live pin level lets software tell a break from a bad frame
  assign stat_w = {lk.tx_active, rxs2_ff, per_ff, fer_ff, overrun_flag_ff, receive_full_flag_ff, tbe_ff}; // [RULE7]
  assign rd_word = ({AXI_DW{rsel[REG_CTRL]}} & AXI_DW'(ctrl_ff))
    | ({AXI_DW{rsel[REG_BAUD]}} & AXI_DW'(baud_ff))
    | ({AXI_DW{rsel[REG_STAT]}} & AXI_DW'(stat_w))
    | ({AXI_DW{rsel[REG_TXD]}} & AXI_DW'(hold_ff))
    | ({AXI_DW{rsel[REG_RXD]}} & AXI_DW'(rbuf_ff))
    | ({AXI_DW{rsel[REG_ISTAT]}} & AXI_DW'(ist_ff))
    | ({AXI_DW{rsel[REG_IMASK]}} & AXI_DW'(imask_ff));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else begin
      arready_ff <= !nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (ar_hs) begin
        rdata_ff <= rd_word;
        rresp_ff <= (|rsel) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Software-written registers
  logic [AXI_DW-1:0] ctrl_m;
  logic [AXI_DW-1:0] baud_m;
  logic [AXI_DW-1:0] hold_m;
  logic [AXI_DW-1:0] imask_m;
  assign ctrl_m = be_merge(AXI_DW'(ctrl_ff), wdata_ff, wstrb_ff);
  assign baud_m = be_merge(AXI_DW'(baud_ff), wdata_ff, wstrb_ff);
  assign hold_m = be_merge(AXI_DW'(hold_ff), wdata_ff, wstrb_ff);
  assign imask_m = be_merge(AXI_DW'(imask_ff), wdata_ff, wstrb_ff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= CTRL_RST;
      baud_ff <= BAUD_RST;
      hold_ff <= '0;
      imask_ff <= '0;
    end else begin
      if (wr_en[REG_CTRL]) begin
        ctrl_ff <= ctrl_m[CTRL_W-1:0];
      end
      if (wr_en[REG_BAUD]) begin
        baud_ff <= baud_m[BAUD_W-1:0];
      end
      // No guard on the empty flag: a pending byte is simply replaced
      if (wr_en[REG_TXD]) begin // [RULE2]
        hold_ff <= hold_m[7:0];
      end
      if (wr_en[REG_IMASK]) begin
        imask_ff <= imask_m[NIRQ-1:0];
      end
    end
  end

  // Base clock at 16x bit rate and pin synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_ff <= '0;
      tick_ff <= 1'b0;
      rxs1_ff <= 1'b1;
      rxs2_ff <= 1'b1;
    end else begin
      div_ff <= (div_ff >= baud_ff) ? '0 : div_ff + 1'b1;
      tick_ff <= (div_ff >= baud_ff);
      rxs1_ff <= rxd_pin;
      rxs2_ff <= rxs1_ff;
    end
  end

  // Receive flags; an event in the cycle of a clear wins
  logic tx_en;
  logic sync_md;
  logic rx_err_any;
  logic st_wr;
  logic [STAT_W-1:0] clr;
  logic rx_ok;
  logic ev_ov;
  logic ev_full;
  logic ev_err;
  logic nxt_tbe;
  assign tx_en = ctrl_ff[CT_TX_EN];
  assign sync_md = ctrl_ff[CT_SYNC];
  assign rx_err_any = overrun_flag_ff || fer_ff || per_ff;
  assign st_wr = wr_en[REG_STAT] && wstrb_ff[0];
  assign clr = {STAT_W{st_wr}} & ~wdata_ff[STAT_W-1:0] & seen_ff; // [RULE19]
  assign rx_ok = lk.rx_done && !receive_full_flag_ff;
  assign ev_ov = lk.rx_done && receive_full_flag_ff; // [RULE4]
  assign ev_full = rx_ok && !lk.rx_ferr && !lk.rx_perr; // [RULE5]
  assign ev_err = ev_ov || (lk.rx_done && (lk.rx_ferr || lk.rx_perr));
  assign nxt_tbe = !tx_en || (!wr_en[REG_TXD] && (tbe_ff || lk.tx_take)); // [RULE1]

  always_ff @(posedge aclk) begin
    // Receive disable does not touch these flags
    if (!aresetn) begin // [RULE13]
      tbe_ff <= 1'b1;
      receive_full_flag_ff <= 1'b0;
      overrun_flag_ff <= 1'b0;
      fer_ff <= 1'b0;
      per_ff <= 1'b0;
      seen_ff <= '0;
      rbuf_ff <= '0;
    end else begin
      tbe_ff <= nxt_tbe;
      receive_full_flag_ff <= ev_full || (receive_full_flag_ff && !clr[ST_RECEIVE_FULL_FLAG]);
      overrun_flag_ff <= ev_ov || (overrun_flag_ff && !clr[ST_OVERRUN_FLAG]); // [RULE4]
      fer_ff <= (lk.rx_done && lk.rx_ferr) || (fer_ff && !clr[ST_FER]); // [RULE6]
      per_ff <= (lk.rx_done && lk.rx_perr) || (per_ff && !clr[ST_PER]);
      seen_ff <= (ar_hs && rsel[REG_STAT]) ? stat_w : (seen_ff & ~clr);
      // Overrun drops the new byte; other errors still deliver it
      if (rx_ok) begin // [RULE5]
        rbuf_ff <= lk.rx_data;
      end
    end
  end

  // Link to transmitter and receiver
  assign lk.base_tick = tick_ff;
  assign lk.sync_mode = sync_md;
  assign lk.par_en = ctrl_ff[CT_PAR_EN] && !sync_md;
  assign lk.par_odd = ctrl_ff[CT_PAR_ODD];
  assign lk.tx_en = tx_en;
  assign lk.tx_go = tx_en && !tbe_ff && !(sync_md && rx_err_any); // [RULE12]
  assign lk.tx_data = hold_ff;
  assign lk.rx_en = ctrl_ff[CT_RX_EN];
  assign lk.rxd = rxs2_ff;

  scu_tx u_tx (
    .aclk(aclk),
    .aresetn(aresetn),
    .lk(lk.tx)
  );

  scu_rx u_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .lk(lk.rx)
  );

  // Interrupt status, mask and outputs
  logic [NIRQ-1:0] ev_irq;
  logic [NIRQ-1:0] w1c;
  logic [NIRQ-1:0] nxt_ist;
  assign ev_irq = {lk.tx_take, ev_err, ev_full};
  assign w1c = (wr_en[REG_ISTAT] && wstrb_ff[0]) ? wdata_ff[NIRQ-1:0] : '0;
  assign nxt_ist = ev_irq | (ist_ff & ~w1c);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ist_ff <= '0;
      irq_ff <= 1'b0;
      err_irq_ff <= 1'b0;
      full_irq_ff <= 1'b0;
    end else begin
      ist_ff <= nxt_ist;
      irq_ff <= |(ist_ff & imask_ff);
      err_irq_ff <= rx_err_any && ctrl_ff[CT_RIE]; // [RULE17]
      full_irq_ff <= receive_full_flag_ff && ctrl_ff[CT_RIE]; // [RULE18]
    end
  end

  // Port latch stands in for the line while transmit is off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd_ff <= 1'b1;
      txd_oe_n_ff <= 1'b1;
      sclk_ff <= 1'b1;
      sclk_oe_n_ff <= 1'b1;
    end else begin
      txd_ff <= tx_en ? lk.tx_sout : ctrl_ff[CT_LATCH]; // [RULE8] [RULE11]
      txd_oe_n_ff <= tx_en ? 1'b0 : !ctrl_ff[CT_DIR]; // [RULE8]
      sclk_ff <= lk.sclk;
      sclk_oe_n_ff <= !(sync_md && tx_en);
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign txd_out = txd_ff;
  assign txd_oe_n = txd_oe_n_ff;
  assign sclk_out = sclk_ff;
  assign sclk_oe_n = sclk_oe_n_ff;
  assign rx_error_irq = err_irq_ff;
  assign rx_full_irq = full_irq_ff;
  assign irq = irq_ff;
endmodule

//--- scu_line_model.sv
// Remote serial device: drives the receive line, decodes the transmit line.
// Assumes BAUD 0, so one bit lasts 16 aclk cycles; the line idles at mark.
`timescale 1ns/100ps
module scu_line_model (
  input wire logic aclk,
  input wire logic txd,
  output logic rxd
);
  initial rxd = 1'b1;
  // Bits leave LSB first, 16 base ticks each
  task automatic sendf(input logic [10:0] f, input int n, input logic last);
    for (int i = 0; i < n; i++) begin
      rxd <= f[i];
      repeat (16) @(posedge aclk);
    end
    rxd <= last;
  endtask
  // Mid-bit sampling of the 8 data bits; waits to the middle of the stop bit without sampling it
  task automatic grab(output logic [7:0] d);
    int t;
    t = 0;
    while (txd !== 1'b0 && t < 4000) begin
      @(posedge aclk);
      t++;
    end
    repeat (8) @(posedge aclk);
    for (int i = 0; i < 9; i++) begin
      repeat (16) @(posedge aclk);
      if (i < 8) d[i] = txd;
    end
  endtask
endmodule

//--- scu_top_chk.sv
// Bus checker for the serial unit top; sees its ports only.
// Assumes one AXI4-Lite master with one write and one read at a time.
`timescale 1ns/100ps
module scu_top_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [scu_pkg::AXI_DW-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import scu_pkg::*;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_b_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b lost");
  a_w_blocked: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  a_b_latency: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1
    s_axi_bvalid) else $error("write answer late");
  a_w_reopens: assert property (
    s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready) else $error("no reopen");
  a_r_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r lost");
  a_r_latency: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready) else $error("read late");
  a_r_blocked: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  a_slverr_zero: assert property (
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
    else $error("error read not zero");
endmodule
bind scu_top scu_top_chk scu_top_chk_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

//--- tb.sv
// Register-level bench of the serial unit with a remote line model.
// Assumes BAUD written to 0, so one serial bit is 16 aclk cycles.
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module tb;
  import scu_pkg::*;
  localparam logic [1:0] OK = RESP_OKAY;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, d1, d2;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rxd_pin;
  logic txd_out, txd_oe_n, sclk_out, sclk_oe_n, rx_error_irq, rx_full_irq, irq;
  int n_fail = 0, check_count = 0, cyc = 0;
  scu_top scu_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxd_pin, .txd_out, .txd_oe_n, .sclk_out,
    .sclk_oe_n, .rx_error_irq, .rx_full_irq, .irq);
  scu_line_model scu_line_model_inst (.aclk, .txd(txd_out), .rxd(rxd_pin));
  always #5 aclk = ~aclk;
  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1 && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid === 1'b1 && s_axi_bready));
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1 && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid === 1'b1 && s_axi_rready));
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, {16'h0000, e})
    `CHK(s_axi_rresp, er)
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(8'h00, 16'h0000, OK);
    rchk(8'h04, 16'h0035, OK);
    rchk(8'h08, 16'h0021, OK);
    rchk(8'h1C, 16'h0000, RESP_SLVERR);
    wr(8'h1C, 16'h00FF, RESP_SLVERR);
    wr(8'h04, 16'h0000, OK);
    wr(8'h00, 16'h0030, OK);
    idle(3);
    `CHK({txd_out, txd_oe_n}, 2'b10)
    wr(8'h00, 16'h0010, OK);
    idle(3);
    `CHK(txd_oe_n, 1'b1)
    wr(8'h00, 16'h0031, OK);
    fork
      begin
        scu_line_model_inst.grab(d1);
        scu_line_model_inst.grab(d2);
      end
      begin
        wr(8'h0C, 16'h0055, OK);
        rchk(8'h08, 16'h0061, OK);
        wr(8'h0C, 16'h00A6, OK);
        wr(8'h0C, 16'h00C3, OK);
        rchk(8'h08, 16'h0060, OK);
      end
    join
    `CHK(d1, 8'h55)
    `CHK(d2, 8'hC3)
    rchk(8'h14, 16'h0004, OK);
    // Abort mid-frame of all-ones data so a low pin can only be the port
    wr(8'h0C, 16'h00FF, OK);
    idle(40);
    wr(8'h00, 16'h0021, OK);
    `CHK(txd_out, 1'b1)
    wr(8'h00, 16'h0020, OK);
    idle(2);
    `CHK({txd_out, txd_oe_n}, 2'b00)
    rchk(8'h08, 16'h0021, OK);
    wr(8'h00, 16'h000A, OK);
    wr(8'h18, 16'h0003, OK);
    scu_line_model_inst.sendf({2'b11, 8'hA5, 1'b0}, 10, 1'b1);
    idle(8);
    rchk(8'h08, 16'h0023, OK);
    `CHK({rx_full_irq, irq}, 2'b11)
    scu_line_model_inst.sendf({2'b00, 8'h3C, 1'b0}, 10, 1'b1);
    idle(8);
    rchk(8'h08, 16'h002F, OK);
    `CHK(rx_error_irq, 1'b1)
    rchk(8'h10, 16'h00A5, OK);
    wr(8'h08, 16'h001E, OK);
    rchk(8'h08, 16'h002F, OK);
    wr(8'h08, 16'h0000, OK);
    rchk(8'h08, 16'h0021, OK);
    scu_line_model_inst.sendf({2'b00, 8'h3C, 1'b0}, 10, 1'b1);
    idle(8);
    rchk(8'h08, 16'h0029, OK);
    rchk(8'h10, 16'h003C, OK);
    wr(8'h08, 16'h0000, OK);
    wr(8'h00, 16'h004A, OK);
    scu_line_model_inst.sendf({2'b10, 8'h01, 1'b0}, 11, 1'b1);
    idle(8);
    rchk(8'h08, 16'h0031, OK);
    rchk(8'h10, 16'h0001, OK);
    wr(8'h08, 16'h0000, OK);
    scu_line_model_inst.sendf(11'h000, 11, 1'b0);
    idle(8);
    rchk(8'h08, 16'h0009, OK);
    wr(8'h08, 16'h0000, OK);
    idle(400);
    rchk(8'h08, 16'h0009, OK);
    wr(8'h00, 16'h0048, OK);
    rchk(8'h08, 16'h0009, OK);
    scu_line_model_inst.sendf(11'h7FF, 1, 1'b1);
    wr(8'h00, 16'h0005, OK);
    wr(8'h0C, 16'h005A, OK);
    idle(20);
    rchk(8'h08, 16'h0028, OK);
    `CHK({sclk_out, sclk_oe_n}, 2'b10)
    wr(8'h08, 16'h0000, OK);
    idle(4);
    `CHK(sclk_out, 1'b0)
    rchk(8'h08, 16'h0061, OK);
    rchk(8'h14, 16'h0007, OK);
    wr(8'h18, 16'h0000, OK);
    idle(2);
    `CHK(irq, 1'b0)
    wr(8'h14, 16'h0007, OK);
    rchk(8'h14, 16'h0000, OK);
    give_verdict();
  end
endmodule
